// ### design/async_tx_pkg.sv
package async_tx_pkg;

  // Register byte addresses on the APB (one aligned word each)
  localparam logic [7:0] status_control_addr = 8'h00;
  localparam logic [7:0] holding_buffer_addr = 8'h04;
  localparam logic [7:0] baud_divisor_addr = 8'h08;
  localparam logic [7:0] receive_control_addr = 8'h0C;
  localparam logic [7:0] irq_flags_addr = 8'h10;
  localparam logic [7:0] irq_enables_addr = 8'h14;

  // Field positions in the transmit status/control register
  localparam int ninth_bit_pos = 0;
  localparam int shift_empty_pos = 1;
  localparam int high_speed_pos = 2;
  localparam int sync_select_pos = 4;
  localparam int enable_pos = 5;
  localparam int nine_bit_pos = 6;
  localparam int clock_source_pos = 7;

  // Serial port enable in the receive status/control register
  localparam int port_enable_pos = 7;

  // Buffer-empty flag and its enable in the flag/enable registers
  localparam int buffer_empty_pos = 4;

  // Values after reset
  localparam logic [7:0] status_control_reset = 8'h02;
  localparam logic [7:0] byte_reset = 8'h00;

  // Baud ticks per bit, less one, in the two speed modes
  localparam logic [5:0] ticks_high_speed = 6'h0F;
  localparam logic [5:0] ticks_low_speed = 6'h3F;

  // Bits in a frame beyond the start bit: data (8 or 9) plus stop
  localparam logic [3:0] bits_eight = 4'h9;
  localparam logic [3:0] bits_nine = 4'hA;

  // Transmitter states, one-hot
  typedef enum logic [2:0]
  {
    st_idle = 3'b001,
    st_wait_tick = 3'b010,
    st_shift = 3'b100
  } tx_state_t;

endpackage

// ### design/async_serial_transmitter.sv
// Summary of operation
// RL1 - Frame: start, eight or nine data, stop
// RL2 - Data leaves least significant bit first
// RL3 - Bit timing from eight-bit baud divisor
// RL4 - Speed select picks x16 or x64 ticks
// RL5 - No hardware parity; ninth bit from software
// RL6 - Sleep halts all transmitter activity; the code still aborts and floats the pin on a disable while asleep
// RL7 - Transmitter runs only with synchronous select clear
// RL8 - Shift register reloads only after stop bit
// RL9 - Transfer in one cycle sets buffer-empty flag
// RL10 - Flag sets regardless of its enable bit
// RL11 - Only a buffer write clears the flag
// RL12 - Shift-empty status bit reads one when empty
// RL13 - Setting enable also sets buffer-empty flag
// RL14 - Shifting waits for data and a tick
// RL15 - Data first, enable afterwards also starts
// RL16 - Empty shift register takes byte at once
// RL17 - Clearing enable aborts and floats the pin
// RL18 - Ninth bit sampled at buffer transfer
// RL19 - Software writes ninth bit before data
// RL20 - Software follows the documented setup order
// RL21 - Port enable needed before pin acts
// RL22 - Idle high, start low, stop high
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module async_serial_transmitter
  import async_tx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep,
  output logic transmit_pin_out,
  output logic transmit_pin_oe,
  output logic tx_irq
);

  // Software-visible state
  logic clock_source_r; // Kept for read-back only
  logic nine_bit_select_r;
  logic transmit_enable_bit_r;
  logic sync_select_r;
  logic baud_high_speed_select_r;
  logic ninth_tx_bit_r;
  logic [7:0] tx_holding_buffer_r;
  logic holding_full_r; // Buffer holds a byte not yet moved
  logic [7:0] baud_divisor_value_r;
  logic [7:0] receive_status_control_r;
  logic tx_buffer_empty_flag_r;
  logic tx_buffer_empty_irq_enable_r;

  // Transmitter state
  tx_state_t state_r;
  logic [9:0] tx_shift_reg_r; // Data bits then stop bit
  logic [3:0] bits_left_r;
  logic [7:0] baud_count_r;
  logic [5:0] tick_count_r;
  logic baud_tick; // One cycle pulse per divided clock

  // Sleep pin comes from outside; two flops before use
  logic sleep_meta_r;
  logic sleep_sync_r;

  // Combined qualifiers
  logic active; // Enabled and asynchronous
  logic apb_write;
  logic apb_read;
  logic buffer_write;
  logic load_now;
  logic bit_done;

  assign apb_write = psel && penable && pwrite;
  assign apb_read = psel && penable && !pwrite;
  assign buffer_write = apb_write && (paddr == holding_buffer_addr);
  assign active = transmit_enable_bit_r && !sync_select_r; // RL7
  assign bit_done = baud_tick && (tick_count_r == 6'h00);

  // Load the shift register only when idle or the stop bit is done
  assign load_now = active && holding_full_r &&
    ((state_r == st_idle) ||
     (state_r == st_shift && bit_done && bits_left_r == 4'h0)); // RL8

  // Synchroniser for sleep
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_meta_r <= 1'b0;
      sleep_sync_r <= 1'b0;
    end
    else
    begin
      sleep_meta_r <= sleep;
      sleep_sync_r <= sleep_meta_r;
    end
  end

  // Control register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_source_r <= status_control_reset[clock_source_pos];
      nine_bit_select_r <= status_control_reset[nine_bit_pos];
      transmit_enable_bit_r <= status_control_reset[enable_pos];
      sync_select_r <= status_control_reset[sync_select_pos];
      baud_high_speed_select_r <= status_control_reset[high_speed_pos];
      ninth_tx_bit_r <= status_control_reset[ninth_bit_pos];
      baud_divisor_value_r <= byte_reset;
      receive_status_control_r <= byte_reset;
      tx_buffer_empty_irq_enable_r <= 1'b0;
    end
    else if (apb_write)
    begin
      // Address decode; unmapped writes are dropped
      if (paddr == status_control_addr)
      begin
        clock_source_r <= pwdata[clock_source_pos];
        nine_bit_select_r <= pwdata[nine_bit_pos];
        transmit_enable_bit_r <= pwdata[enable_pos];
        sync_select_r <= pwdata[sync_select_pos];
        baud_high_speed_select_r <= pwdata[high_speed_pos];
        ninth_tx_bit_r <= pwdata[ninth_bit_pos]; // RL5
      end
      else if (paddr == baud_divisor_addr)
      begin
        baud_divisor_value_r <= pwdata[7:0];
      end
      else if (paddr == receive_control_addr)
      begin
        receive_status_control_r <= pwdata[7:0];
      end
      else if (paddr == irq_enables_addr)
      begin
        tx_buffer_empty_irq_enable_r <= pwdata[buffer_empty_pos];
      end
    end
  end

  // Holding buffer; a write fills it, a transfer empties it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_holding_buffer_r <= byte_reset;
      holding_full_r <= 1'b0;
    end
    else if (buffer_write)
    begin
      tx_holding_buffer_r <= pwdata[7:0];
      holding_full_r <= 1'b1; // RL15
    end
    else if (load_now && !sleep_sync_r)
    begin
      holding_full_r <= 1'b0; // RL9
    end
  end

  // Buffer-empty flag: hardware set wins over the buffer-write clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_buffer_empty_flag_r <= 1'b0;
    end
    else if (load_now && !sleep_sync_r)
    begin
      tx_buffer_empty_flag_r <= 1'b1; // RL9 RL10
    end
    else if (apb_write && paddr == status_control_addr &&
             pwdata[enable_pos] && !transmit_enable_bit_r)
    begin
      tx_buffer_empty_flag_r <= 1'b1; // RL13
    end
    else if (buffer_write)
    begin
      tx_buffer_empty_flag_r <= 1'b0; // RL11
    end
  end

  // Baud generator: divisor+1 cycles per tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_count_r <= byte_reset;
      baud_tick <= 1'b0;
    end
    else if (!active || sleep_sync_r)
    begin
      // Stopped while disabled or asleep
      baud_count_r <= byte_reset; // RL6
      baud_tick <= 1'b0;
    end
    else if (baud_count_r >= baud_divisor_value_r)
    begin
      baud_count_r <= byte_reset; // RL3
      baud_tick <= 1'b1;
    end
    else
    begin
      baud_count_r <= baud_count_r + 8'h01;
      baud_tick <= 1'b0;
    end
  end

  // Transmit state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= st_idle;
      tx_shift_reg_r <= 10'h3FF;
      bits_left_r <= 4'h0;
      tick_count_r <= 6'h00;
      transmit_pin_out <= 1'b1;
    end
    else if (!active)
    begin
      // Abort: reset transmitter, pin floats
      state_r <= st_idle; // RL17
      bits_left_r <= 4'h0;
      tick_count_r <= 6'h00;
      transmit_pin_out <= 1'b1;
    end
    else if (!sleep_sync_r) // RL6
    begin
      case (state_r)
        st_idle:
        begin
          transmit_pin_out <= 1'b1; // RL22
          if (load_now)
          begin
            // Ninth bit sampled here; stop bit appended
            tx_shift_reg_r <= nine_bit_select_r ?
              {1'b1, ninth_tx_bit_r, tx_holding_buffer_r} :
              {2'b11, tx_holding_buffer_r}; // RL1 RL18
            bits_left_r <= nine_bit_select_r ? bits_nine : bits_eight;
            state_r <= st_wait_tick; // RL16
          end
        end
        st_wait_tick:
        begin
          // Start bit begins on the first baud tick
          if (baud_tick)
          begin
            transmit_pin_out <= 1'b0; // RL14 RL22
            tick_count_r <= baud_high_speed_select_r ?
              ticks_high_speed : ticks_low_speed; // RL4
            state_r <= st_shift;
          end
        end
        st_shift:
        begin
          if (baud_tick && tick_count_r != 6'h00)
          begin
            tick_count_r <= tick_count_r - 6'h01;
          end
          else if (bit_done)
          begin
            if (bits_left_r != 4'h0)
            begin
              // Next bit, least significant first; stop is last
              transmit_pin_out <= tx_shift_reg_r[0]; // RL2 RL22
              tx_shift_reg_r <= {1'b1, tx_shift_reg_r[9:1]};
              bits_left_r <= bits_left_r - 4'h1;
              tick_count_r <= baud_high_speed_select_r ?
                ticks_high_speed : ticks_low_speed; // RL4
            end
            else if (load_now)
            begin
              // Back to back: next start bit at once
              tx_shift_reg_r <= nine_bit_select_r ?
                {1'b1, ninth_tx_bit_r, tx_holding_buffer_r} :
                {2'b11, tx_holding_buffer_r}; // RL8 RL18
              bits_left_r <= nine_bit_select_r ? bits_nine : bits_eight;
              transmit_pin_out <= 1'b0;
              tick_count_r <= baud_high_speed_select_r ?
                ticks_high_speed : ticks_low_speed;
            end
            else
            begin
              transmit_pin_out <= 1'b1;
              state_r <= st_idle;
            end
          end
        end
        default:
        begin
          state_r <= st_idle;
        end
      endcase
    end
  end

  // Pin is driven only while enabled, asynchronous, port enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      transmit_pin_oe <= 1'b0;
    end
    else
    begin
      transmit_pin_oe <= active &&
        receive_status_control_r[port_enable_pos]; // RL17 RL21
    end
  end

  // Interrupt request: flag gated by its enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_irq <= 1'b0;
    end
    else
    begin
      tx_irq <= tx_buffer_empty_flag_r && tx_buffer_empty_irq_enable_r;
    end
  end

  // APB read data, registered in the setup cycle; no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == status_control_addr)
        begin
          prdata[7:0] <= {clock_source_r, nine_bit_select_r,
            transmit_enable_bit_r, sync_select_r, 1'b0,
            baud_high_speed_select_r,
            (state_r == st_idle), ninth_tx_bit_r}; // RL12
        end
        else if (paddr == holding_buffer_addr)
        begin
          prdata[7:0] <= tx_holding_buffer_r;
        end
        else if (paddr == baud_divisor_addr)
        begin
          prdata[7:0] <= baud_divisor_value_r;
        end
        else if (paddr == receive_control_addr)
        begin
          prdata[7:0] <= receive_status_control_r;
        end
        else if (paddr == irq_flags_addr)
        begin
          prdata[buffer_empty_pos] <= tx_buffer_empty_flag_r;
        end
        else if (paddr == irq_enables_addr)
        begin
          prdata[buffer_empty_pos] <= tx_buffer_empty_irq_enable_r;
        end
        else
        begin
          pslverr <= 1'b1; // Unmapped read
        end
      end
      else if (psel && !penable)
      begin
        if (paddr != status_control_addr && paddr != holding_buffer_addr &&
            paddr != baud_divisor_addr && paddr != receive_control_addr &&
            paddr != irq_flags_addr && paddr != irq_enables_addr)
        begin
          pslverr <= 1'b1; // Unmapped write
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### tb/async_tx_sva.sv
`timescale 1ns/1ps
`default_nettype none
module async_tx_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep,
  input wire logic transmit_pin_out,
  input wire logic transmit_pin_oe
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // First phase of a bus transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  // Setup aimed past the register map or off word alignment
  sequence s_bad_setup;
    s_setup ##0 (paddr > 8'h14 || paddr[1:0] != 2'b00);
  endsequence
  // Software clearing the enable bit
  sequence s_disable;
    pready && pwrite && paddr == 8'h00 && !pwdata[5];
  endsequence
  property p_ready;
    s_setup |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_unmapped;
    s_bad_setup |=> pslverr;
  endproperty
  property p_upper;
    pready |-> prdata[31:8] == 24'h00_0000;
  endproperty
  property p_abort;
    s_disable |-> ##[1:3] !transmit_pin_oe;
  endproperty
  // Shortest bit is sixteen cycles, so a low level must last eight
  property p_bit_len;
    $fell(transmit_pin_out) && transmit_pin_oe |->
      (!transmit_pin_out || !transmit_pin_oe) [*8];
  endproperty
  // Allows for the two-flop synchroniser before the halt bites
  property p_sleep;
    sleep [*5] |-> $stable(transmit_pin_out) && $stable(transmit_pin_oe);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  a_err_ready: assert property (p_err_ready) else $error("stray error");
  a_unmapped: assert property (p_unmapped) else $error("no error");
  a_upper: assert property (p_upper) else $error("upper read bits set");
  a_abort: assert property (p_abort) else $error("pin still driven");
  a_bit_len: assert property (p_bit_len) else $error("short low bit");
  a_sleep: assert property (p_sleep) else $error("moved while asleep");
endmodule
bind async_serial_transmitter async_tx_sva chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep(sleep), .transmit_pin_out(transmit_pin_out),
  .transmit_pin_oe(transmit_pin_oe));
`default_nettype wire

// ### tb/serial_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_rx_model (
  input wire logic clk,
  input wire logic line,
  input wire logic [15:0] bit_cycles,
  input wire logic nine,
  output logic [8:0] rx_data,
  output logic rx_stop,
  output logic rx_done
);
  initial rx_done = 1'b0;
  // Mid-bit sampling; a start edge is any fall of the line
  always
  begin
    @(negedge line);
    repeat (bit_cycles / 2) @(posedge clk);
    rx_data = 9'h000;
    // Same format as the sender, eight or nine data bits
    for (int i = 0; i < (nine ? 9 : 8); i++)
    begin
      repeat (bit_cycles) @(posedge clk);
      rx_data[i] = line;
    end
    repeat (bit_cycles) @(posedge clk);
    rx_stop = line;
    rx_done = 1'b1;
    @(posedge clk);
    rx_done = 1'b0;
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import async_tx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sleep, pready, pslverr;
  logic pin_out, pin_oe, tx_irq, err, speed, nine, ignore_rx, rx_stop, rx_done;
  logic [7:0] paddr, div;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] rx_data, b9;
  logic [15:0] bit_len;
  logic [8:0] q[$];
  int num_errors = 0;
  int n_compared = 0;
  int seed;
  // Pull-up holds the line high whenever the pin floats
  wire logic line = pin_oe ? pin_out : 1'b1;
  async_serial_transmitter DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .transmit_pin_out(pin_out), .transmit_pin_oe(pin_oe), .tx_irq(tx_irq));
  serial_rx_model rx (.clk(pclk), .line(line), .bit_cycles(bit_len),
    .nine(nine), .rx_data(rx_data), .rx_stop(rx_stop), .rx_done(rx_done));
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  task stop_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One bus transfer; the request stands until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input string name, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(name, e, rd);
  endtask
  function logic [31:0] stat(logic en, logic n9, logic b, logic sp);
    return {24'h00_0000, 1'b0, n9, en, 2'b00, sp, 2'b00} | 32'(b);
  endfunction
  // Bit time in clocks: one tick per divisor+1, 16 or 64 ticks
  function logic [15:0] len_f(logic [7:0] d, logic sp);
    return (16'(d) + 16'h0001) * (sp ? 16'h0010 : 16'h0040);
  endfunction
  // Polling avoids guessing the load latency
  task wait_idle;
    do
      apb(1'b0, status_control_addr, 32'h0000_0000);
    while (rd[shift_empty_pos] !== 1'b1 || q.size() != 0);
  endtask
  // Each received frame, unless ignore_rx is set, must match the oldest queued byte
  always @(posedge rx_done)
    if (!ignore_rx)
      check("frame", {22'h0, 1'b1, q.pop_front()}, {rx_stop, rx_data});
  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    stop_test;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, sleep, nine, ignore_rx} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    seed = $urandom(67);
    div = 8'($urandom_range(1, 0));
    speed = 1'($urandom_range(1, 0));
    bit_len = len_f(div, speed);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("status", status_control_addr, 32'(status_control_reset));
    rdchk("flags", irq_flags_addr, 32'h0000_0000);
    rdchk("unmapped", 8'h40, 32'h0000_0000);
    check("slverr", 32'h1, 32'(err));
    apb(1'b1, baud_divisor_addr, 32'(div));
    rdchk("divisor", baud_divisor_addr, 32'(div));
    apb(1'b1, receive_control_addr, 32'h0000_0080);
    apb(1'b1, irq_enables_addr, 32'h0000_0010);
    // Data before enable must still go out
    q.push_back(9'h0A5);
    apb(1'b1, holding_buffer_addr, 32'h0000_00A5);
    apb(1'b1, status_control_addr, stat(1'b1, 1'b0, 1'b0, speed));
    rdchk("flag on", irq_flags_addr, 32'h0000_0010);
    check("irq", 32'h1, 32'(tx_irq));
    // Queued back to back; ninth bit written ahead of each byte
    for (int i = 0; i < 6; i++)
    begin
      b9 = 9'($urandom);
      if (i == 3)
        wait_idle;
      nine = (i >= 3);
      // Wait for room first, so a queued byte keeps its own ninth bit
      do
        apb(1'b0, irq_flags_addr, 32'h0000_0000);
      while (rd[buffer_empty_pos] !== 1'b1);
      apb(1'b1, status_control_addr, stat(1'b1, nine, b9[8], speed));
      q.push_back(nine ? b9 : {1'b0, b9[7:0]});
      apb(1'b1, holding_buffer_addr, 32'(b9[7:0]));
    end
    wait_idle;
    nine = 1'b0;
    // Rest of the run uses the other speed, so both tick counts are seen
    speed = ~speed;
    bit_len = len_f(div, speed);
    apb(1'b1, status_control_addr, stat(1'b1, 1'b0, 1'b0, speed));
    // Flag stays set under a mask and against a software write
    apb(1'b1, irq_enables_addr, 32'h0000_0000);
    apb(1'b1, irq_flags_addr, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    check("irq masked", 32'h0, 32'(tx_irq));
    rdchk("flag kept", irq_flags_addr, 32'h0000_0010);
    // Held off by sleep, then by synchronous select
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        sleep <= 1'b1;
      else
        apb(1'b1, status_control_addr, stat(1'b1, 1'b0, 1'b0, speed) | 32'h10);
      q.push_back(9'h03C);
      apb(1'b1, holding_buffer_addr, 32'h0000_003C);
      repeat (3 * bit_len) @(posedge pclk);
      check("held", 32'h1, 32'(q.size()));
      sleep <= 1'b0;
      apb(1'b1, status_control_addr, stat(1'b1, 1'b0, 1'b0, speed));
      wait_idle;
    end
    // Abort in mid-frame floats the pin and resets the shifter
    ignore_rx = 1'b1;
    apb(1'b1, holding_buffer_addr, 32'h0000_0081);
    repeat (3 * bit_len) @(posedge pclk);
    // Mid-frame the shifter is full, so its empty bit reads zero
    rdchk("status busy", status_control_addr,
      stat(1'b1, 1'b0, 1'b0, speed));
    apb(1'b1, status_control_addr, stat(1'b0, 1'b0, 1'b0, speed));
    repeat (3) @(posedge pclk);
    check("pin oe", 32'h0, 32'(pin_oe));
    rdchk("status off", status_control_addr,
      stat(1'b0, 1'b0, 1'b0, speed) | 32'h2);
    // A buffer write clears the flag; disabled, nothing moves on
    apb(1'b1, holding_buffer_addr, 32'h0000_005A);
    rdchk("flag clr", irq_flags_addr, 32'h0000_0000);
    // With sync set no load can happen, so only the enable sets the flag
    apb(1'b1, status_control_addr,
      stat(1'b1, 1'b0, 1'b0, speed) | 32'h10);
    rdchk("flag en", irq_flags_addr, 32'h0000_0010);
    repeat (12 * bit_len) @(posedge pclk);
    stop_test;
  end
endmodule
`default_nettype wire
